// ### pkg/crs_pkg.sv
`default_nettype none
package crs_pkg;
  // status word field positions
  localparam int unsigned FLD_TEST = 0;
  localparam int unsigned FLD_SAT = 1;
  localparam int unsigned FLD_IMASK_LO = 4;
  localparam int unsigned FLD_IMASK_HI = 7;
  localparam int unsigned FLD_DIVQ = 8;
  localparam int unsigned FLD_DIVM = 9;
  // values after reset
  localparam logic [3:0] IMASK_RST = 4'hf;
  localparam logic [31:0] VBASE_RST = 32'h00000000;
  localparam logic [31:0] DATA_RST = 32'h00000000;
  // read-ahead and step of the program counter, in bytes
  localparam logic [31:0] PC_AHEAD = 32'h00000004;
  localparam logic [31:0] PC_STEP = 32'h00000002;
  // vector table slots fetched at reset
  localparam logic [31:0] VEC_PC_OFS = 32'h00000000;
  localparam logic [31:0] VEC_SP_OFS = 32'h00000004;
  localparam logic [3:0] SP_IDX = 4'hf;
  // apb register byte offsets
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_GBASE = 8'h04;
  localparam logic [7:0] A_VBASE = 8'h08;
  localparam logic [7:0] A_MAC_HI = 8'h0c;
  localparam logic [7:0] A_MAC_LO = 8'h10;
  localparam logic [7:0] A_RLINK = 8'h14;
  localparam logic [7:0] A_PC = 8'h18;
  localparam logic [7:0] A_CORE = 8'h1c;
  // load sizes
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } crs_size_t;
  // pipeline system register write select
  typedef enum logic [2:0] {
    SEL_STATUS = 3'h0,
    SEL_GBASE = 3'h1,
    SEL_VBASE = 3'h2,
    SEL_MAC_HI = 3'h3,
    SEL_MAC_LO = 3'h4,
    SEL_RLINK = 3'h5
  } crs_sel_t;
  // reset vector fetch sequencer
  typedef enum logic [2:0] {
    ST_FETCH_PC = 3'b001,
    ST_FETCH_SP = 3'b010,
    ST_RUN = 3'b100
  } crs_state_t;
endpackage
`default_nettype wire

// ### hdl/crs_load_extend.sv
`timescale 1ns/1ps
`default_nettype none
module crs_load_extend (
  // memory data and access size
  input wire logic [31:0] mem_data,
  input wire crs_pkg::crs_size_t size,
  // register-width result
  output logic [31:0] reg_data
);
  // byte and word loads copy their top bit upward
  always_comb begin
    case (size)
      crs_pkg::SZ_BYTE: reg_data = {{24{mem_data[7]}}, mem_data[7:0]};
      crs_pkg::SZ_WORD: reg_data = {{16{mem_data[15]}}, mem_data[15:0]};
      default: reg_data = mem_data;
    endcase
  end
endmodule // crs_load_extend
`default_nettype wire

// ### hdl/crs_gpr_file.sv
`timescale 1ns/1ps
`default_nettype none
module crs_gpr_file (
  // clock
  input wire logic pclk,
  // write port
  input wire logic we,
  input wire logic [3:0] widx,
  input wire logic [31:0] wdata,
  // read ports
  input wire logic [3:0] ridx_a,
  input wire logic [3:0] ridx_b,
  output logic [31:0] rdata_a,
  output logic [31:0] rdata_b,
  output logic [31:0] sp
);
  logic [31:0] regs [16];

  // no reset: contents are undefined until written, the stack slot is filled by the vector fetch
  always_ff @(posedge pclk) begin
    if (we) begin
      regs[widx] <= wdata;
    end
  end

  // reads are combinational so the pipeline sees a same-cycle operand
  assign rdata_a = regs[ridx_a];
  assign rdata_b = regs[ridx_b];
  assign sp = regs[crs_pkg::SP_IDX];
endmodule // crs_gpr_file
`default_nettype wire

// ### hdl/crs_regset.sv
`timescale 1ns/1ps
`default_nettype none
module crs_regset (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset vector fetch
  output logic vec_req,
  output logic [31:0] vec_addr,
  input wire logic vec_ack,
  input wire logic [31:0] vec_rdata,
  output logic core_run,
  // flag updates from execution
  input wire logic t_we,
  input wire logic t_in,
  input wire logic mq_we,
  input wire logic m_in,
  input wire logic q_in,
  // system register writes from execution
  input wire logic sys_we,
  input wire crs_pkg::crs_sel_t sys_sel,
  input wire logic [31:0] sys_wdata,
  input wire logic mac_we,
  input wire logic [31:0] mac_hi_in,
  input wire logic [31:0] mac_lo_in,
  // program counter control
  input wire logic pc_step,
  input wire logic pc_load,
  input wire logic [31:0] pc_target,
  // conditional branch
  input wire logic branch_req,
  input wire logic branch_on_true,
  output logic branch_taken,
  // general registers
  input wire logic gpr_we,
  input wire logic [3:0] gpr_widx,
  input wire logic [31:0] gpr_wdata,
  input wire logic ld_we,
  input wire logic [3:0] ld_idx,
  input wire crs_pkg::crs_size_t ld_size,
  input wire logic [31:0] ld_data,
  input wire logic [3:0] gpr_ridx_a,
  input wire logic [3:0] gpr_ridx_b,
  output logic [31:0] gpr_rdata_a,
  output logic [31:0] gpr_rdata_b,
  output logic [31:0] stack_pointer_gpr,
  // register views for execution
  output logic [31:0] status_word,
  output logic [31:0] global_base,
  output logic [31:0] vector_base,
  output logic [31:0] multiply_acc_high,
  output logic [31:0] multiply_acc_low,
  output logic [31:0] return_link,
  output logic [31:0] pc_read
);
  crs_pkg::crs_state_t state;
  crs_pkg::crs_state_t next_state;
  logic t_flag, s_flag, q_flag, m_flag;
  logic [3:0] interrupt_mask_level;
  logic [31:0] pc;
  logic running, apb_wr, apb_setup, hit, ext_we;
  logic [31:0] rd_mux, ext_data, gpr_wd;
  logic [3:0] gpr_wi;
  logic gpr_w;

  assign running = (state == crs_pkg::ST_RUN);
  assign core_run = running;

  // reset vector fetch: program counter first, then the stack slot
  always_comb begin
    case (state)
      crs_pkg::ST_FETCH_PC: next_state = vec_ack ? crs_pkg::ST_FETCH_SP : crs_pkg::ST_FETCH_PC;
      crs_pkg::ST_FETCH_SP: next_state = vec_ack ? crs_pkg::ST_RUN : crs_pkg::ST_FETCH_SP;
      crs_pkg::ST_RUN: next_state = crs_pkg::ST_RUN;
      default: next_state = crs_pkg::ST_FETCH_PC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= crs_pkg::ST_FETCH_PC;
    end else begin
      state <= next_state;
    end
  end

  // table slots are relative to the vector base, which is zero while fetching
  assign vec_req = !running;
  assign vec_addr = vector_base + ((state == crs_pkg::ST_FETCH_PC) ? crs_pkg::VEC_PC_OFS : crs_pkg::VEC_SP_OFS);

  // apb: zero wait states, writes refused until the vector fetch is done
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && hit && running;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!hit || (pwrite && (!running || paddr == crs_pkg::A_PC
                   || paddr == crs_pkg::A_CORE)));

  // read view of the status word, reserved positions forced to zero
  always_comb begin
    status_word = '0;
    status_word[crs_pkg::FLD_DIVM] = m_flag;
    status_word[crs_pkg::FLD_DIVQ] = q_flag;
    status_word[crs_pkg::FLD_IMASK_HI:crs_pkg::FLD_IMASK_LO] = interrupt_mask_level;
    status_word[crs_pkg::FLD_SAT] = s_flag;
    status_word[crs_pkg::FLD_TEST] = t_flag;
  end

  // address decode and read mux
  always_comb begin
    hit = 1'b1;
    case (paddr)
      crs_pkg::A_STATUS: rd_mux = status_word;
      crs_pkg::A_GBASE: rd_mux = global_base;
      crs_pkg::A_VBASE: rd_mux = vector_base;
      crs_pkg::A_MAC_HI: rd_mux = multiply_acc_high;
      crs_pkg::A_MAC_LO: rd_mux = multiply_acc_low;
      crs_pkg::A_RLINK: rd_mux = return_link;
      crs_pkg::A_PC: rd_mux = pc_read;
      crs_pkg::A_CORE: rd_mux = {31'h0, running};
      default: begin
        rd_mux = '0;
        hit = 1'b0;
      end
    endcase
  end

  // read data captured in the setup cycle so it stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= crs_pkg::DATA_RST;
    end else if (apb_setup) begin
      prdata <= pwrite ? crs_pkg::DATA_RST : rd_mux;
    end
  end

  // test flag: software write wins over the pipeline on a clash
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_flag <= 1'b0;
    end else if (apb_wr && paddr == crs_pkg::A_STATUS) begin
      t_flag <= pwdata[crs_pkg::FLD_TEST];
    end else if (running && sys_we && sys_sel == crs_pkg::SEL_STATUS) begin
      t_flag <= sys_wdata[crs_pkg::FLD_TEST];
    end else if (running && t_we) begin
      t_flag <= t_in;
    end
  end

  // saturate flag and interrupt mask are plain read-write fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_flag <= 1'b0;
      interrupt_mask_level <= crs_pkg::IMASK_RST;
    end else if (apb_wr && paddr == crs_pkg::A_STATUS) begin
      s_flag <= pwdata[crs_pkg::FLD_SAT];
      interrupt_mask_level <= pwdata[crs_pkg::FLD_IMASK_HI:crs_pkg::FLD_IMASK_LO];
    end else if (running && sys_we && sys_sel == crs_pkg::SEL_STATUS) begin
      s_flag <= sys_wdata[crs_pkg::FLD_SAT];
      interrupt_mask_level <= sys_wdata[crs_pkg::FLD_IMASK_HI:crs_pkg::FLD_IMASK_LO];
    end
  end

  // divide flags carry state between setup and step instructions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_flag <= 1'b0;
      q_flag <= 1'b0;
    end else if (apb_wr && paddr == crs_pkg::A_STATUS) begin
      m_flag <= pwdata[crs_pkg::FLD_DIVM];
      q_flag <= pwdata[crs_pkg::FLD_DIVQ];
    end else if (running && sys_we && sys_sel == crs_pkg::SEL_STATUS) begin
      m_flag <= sys_wdata[crs_pkg::FLD_DIVM];
      q_flag <= sys_wdata[crs_pkg::FLD_DIVQ];
    end else if (running && mq_we) begin
      m_flag <= m_in;
      q_flag <= q_in;
    end
  end

  // control bases; global base reset value is arbitrary since nothing may rely on it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_base <= crs_pkg::DATA_RST;
      vector_base <= crs_pkg::VBASE_RST;
    end else if (apb_wr) begin
      if (paddr == crs_pkg::A_GBASE) global_base <= pwdata;
      if (paddr == crs_pkg::A_VBASE) vector_base <= pwdata;
    end else if (running && sys_we) begin
      if (sys_sel == crs_pkg::SEL_GBASE) global_base <= sys_wdata;
      if (sys_sel == crs_pkg::SEL_VBASE) vector_base <= sys_wdata;
    end
  end

  // multiply-accumulate pair: a product write updates both halves together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multiply_acc_high <= crs_pkg::DATA_RST;
      multiply_acc_low <= crs_pkg::DATA_RST;
    end else if (apb_wr && (paddr == crs_pkg::A_MAC_HI || paddr == crs_pkg::A_MAC_LO)) begin
      if (paddr == crs_pkg::A_MAC_HI) multiply_acc_high <= pwdata;
      if (paddr == crs_pkg::A_MAC_LO) multiply_acc_low <= pwdata;
    end else if (running && mac_we) begin
      multiply_acc_high <= mac_hi_in;
      multiply_acc_low <= mac_lo_in;
    end else if (running && sys_we) begin
      if (sys_sel == crs_pkg::SEL_MAC_HI) multiply_acc_high <= sys_wdata;
      if (sys_sel == crs_pkg::SEL_MAC_LO) multiply_acc_low <= sys_wdata;
    end
  end

  // return link, written on subroutine call
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      return_link <= crs_pkg::DATA_RST;
    end else if (apb_wr && paddr == crs_pkg::A_RLINK) begin
      return_link <= pwdata;
    end else if (running && sys_we && sys_sel == crs_pkg::SEL_RLINK) begin
      return_link <= sys_wdata;
    end
  end

  // program counter holds the executing address; the visible value runs ahead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= crs_pkg::DATA_RST;
    end else if (state == crs_pkg::ST_FETCH_PC && vec_ack) begin
      pc <= vec_rdata;
    end else if (running && pc_load) begin
      pc <= pc_target;
    end else if (running && pc_step) begin
      pc <= pc + crs_pkg::PC_STEP;
    end
  end
  assign pc_read = pc + crs_pkg::PC_AHEAD;

  // branch decision reads the stored flag, so a same-cycle update is not seen
  assign branch_taken = branch_req && (t_flag == branch_on_true);

  // load data path
  assign ext_we = running && ld_we;
  crs_load_extend u_ext (
    .mem_data(ld_data),
    .size(ld_size),
    .reg_data(ext_data)
  );

  // one write port: vector fetch, then loads, then alu results
  always_comb begin
    gpr_w = 1'b0;
    gpr_wi = gpr_widx;
    gpr_wd = gpr_wdata;
    if (state == crs_pkg::ST_FETCH_SP && vec_ack) begin
      gpr_w = 1'b1;
      gpr_wi = crs_pkg::SP_IDX;
      gpr_wd = vec_rdata;
    end else if (ext_we) begin
      gpr_w = 1'b1;
      gpr_wi = ld_idx;
      gpr_wd = ext_data;
    end else if (running && gpr_we) begin
      gpr_w = 1'b1;
    end
  end

  crs_gpr_file u_gpr (
    .pclk(pclk),
    .we(gpr_w),
    .widx(gpr_wi),
    .wdata(gpr_wd),
    .ridx_a(gpr_ridx_a),
    .ridx_b(gpr_ridx_b),
    .rdata_a(gpr_rdata_a),
    .rdata_b(gpr_rdata_b),
    .sp(stack_pointer_gpr)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pc_fetched;
    state == crs_pkg::ST_FETCH_PC && vec_ack;
  endsequence
  sequence s_sp_fetched;
    state == crs_pkg::ST_FETCH_SP && vec_ack;
  endsequence

  rsv_bits_zero_a: assert property (status_word[31:10] == '0 && status_word[3:2] == '0)
    else $error("reserved status bits not zero");
  mask_at_reset_a: assert property (!running |-> interrupt_mask_level == 4'hf)
    else $error("interrupt mask not 1111 before run");
  vbase_at_reset_a: assert property (!running |-> vector_base == 32'h0)
    else $error("vector base not zero before run");
  pc_vec_load_a: assert property (s_pc_fetched |=> pc_read == $past(vec_rdata) + 32'h4)
    else $error("pc not loaded from vector slot");
  sp_vec_load_a: assert property (s_sp_fetched |=> stack_pointer_gpr == $past(vec_rdata))
    else $error("stack pointer not loaded from vector slot");
  pc_step_a: assert property (running && pc_step && !pc_load |=> pc_read == $past(pc_read) + 32'h2)
    else $error("pc did not advance one instruction");
  tflag_cap_a: assert property (running && t_we && !sys_we && !apb_wr |=> t_flag == $past(t_in))
    else $error("test flag missed update");
  branch_use_a: assert property (t_we && running && !sys_we && !apb_wr ##1 branch_req
    |-> branch_taken == ($past(t_in) == branch_on_true))
    else $error("branch ignored test flag");
  mac_write_a: assert property (running && mac_we && !apb_wr |=> multiply_acc_high == $past(mac_hi_in)
    && multiply_acc_low == $past(mac_lo_in))
    else $error("mac pair not written");
  divq_hold_a: assert property (running && !mq_we && !sys_we && !apb_wr |=> $stable({m_flag, q_flag}))
    else $error("divide flags changed without cause");
endmodule // crs_regset
`default_nettype wire

// ### verification/crs_vec_model.sv
`timescale 1ns/1ps
`default_nettype none
// vector table memory answering the reset fetch after a chosen number of cycles
module crs_vec_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fetch request and answer
  input wire logic vec_req,
  input wire logic [31:0] vec_addr,
  output logic vec_ack,
  output logic [31:0] vec_rdata,
  // table contents and answer delay
  input wire logic [31:0] pc_val,
  input wire logic [31:0] sp_val,
  input wire logic [3:0] delay
);
  logic [3:0] wait_cnt;
  // one-cycle answer; data toggles outside an answer so stale values never look valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_ack <= 1'h0;
      wait_cnt <= 4'h0;
      vec_rdata <= 32'h5a5a5a5a;
    end else if (vec_req && !vec_ack && wait_cnt >= delay) begin
      vec_ack <= 1'h1;
      wait_cnt <= 4'h0;
      vec_rdata <= vec_addr[2] ? sp_val : pc_val;
    end else begin
      vec_ack <= 1'h0;
      wait_cnt <= (vec_req && !vec_ack) ? wait_cnt + 4'h1 : 4'h0;
      vec_rdata <= ~vec_rdata;
    end
  end
endmodule // crs_vec_model
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic t_we = 1'h0, t_in = 1'h0, mq_we = 1'h0, m_in = 1'h0, q_in = 1'h0, sys_we = 1'h0, mac_we = 1'h0;
  logic pc_step = 1'h0, pc_load = 1'h0, branch_req = 1'h0, branch_on_true = 1'h0, gpr_we = 1'h0, ld_we = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, sys_wdata = 32'h0, mac_hi_in = 32'h0, mac_lo_in = 32'h0, pc_target = 32'h0;
  logic [31:0] gpr_wdata = 32'h0, ld_data = 32'h0, pc_val = 32'h0, sp_val = 32'h0;
  crs_pkg::crs_sel_t sys_sel = crs_pkg::SEL_STATUS;
  crs_pkg::crs_size_t ld_size = crs_pkg::SZ_BYTE;
  logic [3:0] gpr_widx = 4'h0, ld_idx = 4'h0, gpr_ridx_a = 4'h0, gpr_ridx_b = 4'h0, delay = 4'h0;
  logic [31:0] prdata, vec_addr, vec_rdata, gpr_rdata_a, gpr_rdata_b, stack_pointer_gpr, status_word;
  logic [31:0] global_base, vector_base, multiply_acc_high, multiply_acc_low, return_link, pc_read;
  logic pready, pslverr, vec_req, vec_ack, core_run, branch_taken, er;
  int err_total = 0, cmp_count = 0;
  logic [31:0] seed = 32'h0bd8a523, d, e, rd, pcv, spv;

  // design and vector table model
  crs_regset dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .vec_req, .vec_addr, .vec_ack, .vec_rdata, .core_run, .t_we, .t_in, .mq_we, .m_in, .q_in,
    .sys_we, .sys_sel, .sys_wdata, .mac_we, .mac_hi_in, .mac_lo_in, .pc_step, .pc_load, .pc_target,
    .branch_req, .branch_on_true, .branch_taken, .gpr_we, .gpr_widx, .gpr_wdata, .ld_we, .ld_idx,
    .ld_size, .ld_data, .gpr_ridx_a, .gpr_ridx_b, .gpr_rdata_a, .gpr_rdata_b, .stack_pointer_gpr,
    .status_word, .global_base, .vector_base, .multiply_acc_high, .multiply_acc_low, .return_link, .pc_read);
  crs_vec_model model (.pclk, .presetn, .vec_req, .vec_addr, .vec_ack, .vec_rdata, .pc_val, .sp_val, .delay);

  // 25 MHz clock
  always #20 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected register value of a sized load
  function automatic logic [31:0] ext(input int s, input logic [31:0] x);
    if (s == 0) return {{24{x[7]}}, x[7:0]};
    if (s == 1) return {{16{x[15]}}, x[15:0]};
    return x;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one apb transfer; the answer is taken at the rising edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // no wait-state count is assumed; only the watchdog ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    pwrite <= 1'h0;
  endtask

  // one edge with the strobes set by the caller, then they drop
  task automatic settle;
    @(posedge pclk);
    {t_we, mq_we, sys_we, mac_we, pc_step, pc_load, gpr_we, ld_we} <= 8'h00;
    branch_req <= 1'h0;
    @(negedge pclk);
  endtask

  task automatic rst_on(input logic [3:0] dl);
    pcv = xs() & 32'hfffffffe;
    spv = xs() & 32'hfffffffc;
    @(posedge pclk);
    presetn <= 1'h0;
    pc_val <= pcv;
    sp_val <= spv;
    delay <= dl;
    repeat (1) @(posedge pclk);
    @(negedge pclk);
    chk(status_word & 32'hfffffcfc, 32'h000000f0);
    chk(vector_base, 32'h00000000);
    chk({31'h0, vec_req}, 32'h1);
    chk(vec_addr, 32'h00000000);
    @(posedge pclk);
    presetn <= 1'h1;
  endtask

  task automatic wait_run;
    int n;
    n = 0;
    while (core_run !== 1'h1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    chk({31'h0, core_run}, 32'h1);
    chk(pc_read, pcv + 32'h4);
    chk(stack_pointer_gpr, spv);
    e = pcv + 32'h4;
  endtask

  // watchdog
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    conclude();
  end

  initial begin
    rst_on(4'h0);
    wait_run();
    apb(1'h0, 8'h00, 32'h0);
    chk(rd & 32'hfffffcfc, 32'h000000f0);
    // read-write system and control registers
    for (int i = 1; i < 6; i++) begin
      d = xs();
      apb(1'h1, 8'(i * 4), d);
      apb(1'h0, 8'(i * 4), 32'h0);
      chk(rd, d);
    end
    d = xs() & 32'h000003f3;
    apb(1'h1, 8'h00, d);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, d);
    chk(status_word, d);
    apb(1'h0, 8'h20, 32'h0);
    chk(rd, 32'h00000000);
    chk({31'h0, er}, 32'h1);
    apb(1'h0, 8'h1c, 32'h0);
    chk(rd, 32'h00000001);
    apb(1'h1, 8'h18, xs());
    chk({31'h0, er}, 32'h1);
    chk(pc_read, e);
    // test flag and branch decision
    for (int v = 0; v < 2; v++) begin
      @(posedge pclk);
      t_we <= 1'h1;
      t_in <= v[0];
      // branch asked in the cycle right after the flag update, then asked again with the other polarity one cycle later
      for (int b = 0; b < 2; b++) begin
        @(posedge pclk);
        t_we <= 1'h0;
        branch_req <= 1'h1;
        branch_on_true <= b[0];
        @(negedge pclk);
        chk({31'h0, status_word[0]}, 32'(v));
        chk({31'h0, branch_taken}, 32'(b == v));
      end
      settle();
    end
    d = xs();
    @(posedge pclk);
    mq_we <= 1'h1;
    m_in <= d[0];
    q_in <= d[1];
    settle();
    chk({30'h0, status_word[9:8]}, {30'h0, d[0], d[1]});
    // pipeline writes to each register, read back over apb
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? xs() & 32'h000003f3 : xs();
      @(posedge pclk);
      sys_we <= 1'h1;
      sys_sel <= crs_pkg::crs_sel_t'(i);
      sys_wdata <= d;
      settle();
      apb(1'h0, 8'(i * 4), 32'h0);
      chk(rd, d);
      if (i == 1) chk(global_base, d);
    end
    chk(return_link, d);
    d = xs();
    @(posedge pclk);
    mac_we <= 1'h1;
    mac_hi_in <= d;
    mac_lo_in <= ~d;
    settle();
    chk(multiply_acc_high, d);
    chk(multiply_acc_low, ~d);
    // program counter stepping and load over step
    @(posedge pclk);
    pc_step <= 1'h1;
    settle();
    chk(pc_read, e + 32'h2);
    d = xs() & 32'hfffffffe;
    @(posedge pclk);
    pc_step <= 1'h1;
    pc_load <= 1'h1;
    pc_target <= d;
    settle();
    chk(pc_read, d + 32'h4);
    // sized loads, sign bit set then clear
    for (int i = 0; i < 6; i++) begin
      d = (i < 3) ? xs() | 32'h00008080 : xs() & 32'hffff7f7f;
      @(posedge pclk);
      ld_we <= 1'h1;
      ld_idx <= 4'(i);
      ld_size <= crs_pkg::crs_size_t'(i % 3);
      ld_data <= d;
      gpr_ridx_a <= 4'(i);
      settle();
      chk(gpr_rdata_a, ext(i % 3, d));
    end
    d = xs();
    @(posedge pclk);
    gpr_we <= 1'h1;
    gpr_widx <= 4'hf;
    gpr_wdata <= d;
    gpr_ridx_b <= 4'hf;
    settle();
    chk(stack_pointer_gpr, d);
    chk(gpr_rdata_b, d);
    // second reset in mid-run with a slow table; early writes are refused
    rst_on(4'h3);
    apb(1'h1, 8'h04, xs());
    chk({31'h0, er}, 32'h1);
    wait_run();
    conclude();
  end
endmodule // testbench
`default_nettype wire
